// ===== hdl/usb_irq_index.sv
/*
 Common bus interrupt status and enable, endpoint interrupt enables,
 frame number and endpoint select with its indexed window.
 Assumes bus events arrive as one-cycle pulses synchronous to CORE_CLK
 and a register master that never issues read and write together.
*/
// Contract
// - Bit 7 sets when bus supply drops below valid during session.
// - Reading the common status register clears all active bits.
// - Bit 6 sets on session request signalling.
// - Bit 5 sets on host disconnect or peripheral session end.
// - Bit 4 sets when a device connection is detected.
// - Bit 3 sets at the start of every frame.
// - Bit 2 sets on peripheral bus reset or host babble.
// - Bit 1 sets on resume signalling while suspended.
// - Bit 0 sets when suspend signalling is detected.
// - Common enables per status bit; reset and resume enables reset high.
// - Transmit enables bits 4-0 reset high, upper bits read zero.
// - Receive enables bits 4-1 reset high, others read zero.
// - Frame number is read-only eleven bits, upper bits zero.
// - Endpoint select is four bits R/W reset zero, upper zero.
// - Indexed window maps registers of the selected endpoint.
`include "usb_irq_regs.svh"

module usb_irq_index #(
	parameter int NUM_EP = 16,
	parameter int CSR_WORDS = 8
) (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [15:0] RDATA,
	input wire logic IS_HOST,
	input wire logic IS_A_DEVICE,
	input wire logic IN_SESSION,
	input wire logic SUSPENDED,
	input wire logic SUPPLY_LOW,
	input wire logic SESS_REQ_SEEN,
	input wire logic DISCONNECT_SEEN,
	input wire logic SESSION_END,
	input wire logic CONNECT_SEEN,
	input wire logic FRAME_START,
	input wire logic [10:0] FRAME_RX_NUM,
	input wire logic BUS_RESET_SEEN,
	input wire logic BABBLE_SEEN,
	input wire logic RESUME_SEEN,
	input wire logic SUSPEND_SEEN,
	output logic BUS_IRQ,
	output logic NATIVE_IRQ_ACCESS,
	output logic [3:0] ENDPOINT_SEL,
	output logic [15:0] TX_IRQ_EN,
	output logic [15:0] RX_IRQ_EN
);
	localparam int EPW = $clog2(NUM_EP);
	localparam int CW = $clog2(CSR_WORDS);
	localparam int MW = EPW + CW;

	usb_irq_pkg::bus_irq_t status_vec;
	logic supply_error_flag_ff;
	logic session_request_flag_ff;
	logic disconnect_flag_ff;
	logic connect_flag_ff;
	logic frame_start_flag_ff;
	logic reset_babble_flag_ff;
	logic resume_flag_ff;
	logic suspend_flag_ff;
	logic stat_rd;
	logic [15:0] rd_raw;
	usb_irq_pkg::bus_irq_t nxt_status;
	usb_irq_pkg::bus_irq_t events;
	usb_irq_pkg::bus_irq_t bus_en_ff;
	usb_irq_pkg::reg_data_t tx_en_ff;
	usb_irq_pkg::reg_data_t rx_en_ff;
	logic [10:0] frame_ff;
	logic [3:0] ep_sel_ff;
	logic native_ff;
	logic irq_ff;
	logic [15:0] rdata_ff;
	logic rd_win_ff;
	logic [15:0] mem_rdata;
	logic win_hit;
	logic [MW-1:0] mem_addr;
	usb_irq_pkg::role_t role;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
		hit = (a == o);
	endfunction

	function automatic logic [15:0] read_mask(input logic [3:0] a);
		if (hit(a, `TX_IRQ_EN_OFS)) begin
			read_mask = `TX_IRQ_EN_MASK;
		end else if (hit(a, `RX_IRQ_EN_OFS)) begin
			read_mask = `RX_IRQ_EN_MASK;
		end else if (hit(a, `BUS_IRQ_STAT_OFS) || hit(a, `BUS_IRQ_EN_OFS)) begin
			read_mask = `BUS_IRQ_MASK;
		end else if (hit(a, `FRAME_NUM_OFS)) begin
			read_mask = `FRAME_NUM_MASK;
		end else if (hit(a, `EP_SEL_OFS)) begin
			read_mask = `EP_SEL_MASK;
		end else if (hit(a, `MODE_CTRL_OFS)) begin
			read_mask = `MODE_CTRL_MASK;
		end else begin
			read_mask = 16'h0000;
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Event mapping
	always_comb begin
		role = IS_HOST ? usb_irq_pkg::ROLE_HOST
			: usb_irq_pkg::ROLE_PERIPHERAL;
		events = '0;
		events[`SUPPLY_ERR_BIT] = SUPPLY_LOW & IN_SESSION & IS_A_DEVICE;
		events[`SESS_REQ_BIT] = SESS_REQ_SEEN & IS_A_DEVICE;
		events[`DISCONNECT_BIT] = (role == usb_irq_pkg::ROLE_HOST)
			? DISCONNECT_SEEN : SESSION_END;
		events[`CONNECT_BIT] = CONNECT_SEEN
			& (role == usb_irq_pkg::ROLE_HOST);
		events[`FRAME_START_BIT] = FRAME_START;
		events[`RESET_BABBLE_BIT] = (role == usb_irq_pkg::ROLE_HOST)
			? BABBLE_SEEN : BUS_RESET_SEEN;
		events[`RESUME_BIT] = RESUME_SEEN & SUSPENDED;
		events[`SUSPEND_BIT] = SUSPEND_SEEN
			& (role == usb_irq_pkg::ROLE_PERIPHERAL);
	end

	//////////////////////////////////////////////////////////////////////
	// Sticky status, cleared by read, new events win
	assign stat_rd = RD && hit(ADDR, `BUS_IRQ_STAT_OFS);

	always_comb begin
		nxt_status = status_vec;
		if (stat_rd) begin
			nxt_status = `STATUS_RST;
		end
		nxt_status = nxt_status | events;
	end

	always_comb begin
		status_vec = `STATUS_RST;
		status_vec[`SUPPLY_ERR_BIT] = supply_error_flag_ff;
		status_vec[`SESS_REQ_BIT] = session_request_flag_ff;
		status_vec[`DISCONNECT_BIT] = disconnect_flag_ff;
		status_vec[`CONNECT_BIT] = connect_flag_ff;
		status_vec[`FRAME_START_BIT] = frame_start_flag_ff;
		status_vec[`RESET_BABBLE_BIT] = reset_babble_flag_ff;
		status_vec[`RESUME_BIT] = resume_flag_ff;
		status_vec[`SUSPEND_BIT] = suspend_flag_ff;
	end

	// Supply error flag
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			supply_error_flag_ff <= `FLAG_RST;
		end else begin
			supply_error_flag_ff <= nxt_status[`SUPPLY_ERR_BIT];
		end
	end

	// Session request flag
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			session_request_flag_ff <= `FLAG_RST;
		end else begin
			session_request_flag_ff <= nxt_status[`SESS_REQ_BIT];
		end
	end

	// Disconnect flag
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			disconnect_flag_ff <= `FLAG_RST;
		end else begin
			disconnect_flag_ff <= nxt_status[`DISCONNECT_BIT];
		end
	end

	// Connect flag
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			connect_flag_ff <= `FLAG_RST;
		end else begin
			connect_flag_ff <= nxt_status[`CONNECT_BIT];
		end
	end

	// Frame start flag
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			frame_start_flag_ff <= `FLAG_RST;
		end else begin
			frame_start_flag_ff <= nxt_status[`FRAME_START_BIT];
		end
	end

	// Reset or babble flag
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			reset_babble_flag_ff <= `FLAG_RST;
		end else begin
			reset_babble_flag_ff <= nxt_status[`RESET_BABBLE_BIT];
		end
	end

	// Resume flag
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			resume_flag_ff <= `FLAG_RST;
		end else begin
			resume_flag_ff <= nxt_status[`RESUME_BIT];
		end
	end

	// Suspend flag
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			suspend_flag_ff <= `FLAG_RST;
		end else begin
			suspend_flag_ff <= nxt_status[`SUSPEND_BIT];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Writable registers and frame number capture
	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			bus_en_ff <= `BUS_IRQ_EN_RST;
		end else if (WR && hit(ADDR, `BUS_IRQ_EN_OFS)) begin
			bus_en_ff <= WDATA[7:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			tx_en_ff <= `TX_IRQ_EN_RST;
		end else if (WR && hit(ADDR, `TX_IRQ_EN_OFS)) begin
			tx_en_ff <= WDATA & `TX_IRQ_EN_MASK;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			rx_en_ff <= `RX_IRQ_EN_RST;
		end else if (WR && hit(ADDR, `RX_IRQ_EN_OFS)) begin
			rx_en_ff <= WDATA & `RX_IRQ_EN_MASK;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			ep_sel_ff <= `EP_SEL_RST;
		end else if (WR && hit(ADDR, `EP_SEL_OFS)) begin
			ep_sel_ff <= WDATA[3:0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			native_ff <= `NATIVE_RST;
		end else if (WR && hit(ADDR, `MODE_CTRL_OFS)) begin
			native_ff <= WDATA[0];
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			frame_ff <= `FRAME_NUM_RST;
		end else if (FRAME_START) begin
			frame_ff <= FRAME_RX_NUM;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Indexed window
	assign win_hit = (ADDR >= `IDX_WIN_OFS);
	assign mem_addr = {ep_sel_ff[EPW-1:0], ADDR[CW-1:0]};

	ep_csr_mem #(
		.DEPTH(NUM_EP * CSR_WORDS),
		.WIDTH(16)
	) u_csr_mem (
		.clk(CORE_CLK),
		.wr_en(WR && win_hit),
		.wr_addr(mem_addr),
		.wr_data(WDATA),
		.rd_addr(mem_addr),
		.rd_data_ff(mem_rdata)
	);

	//////////////////////////////////////////////////////////////////////
	// Read data and interrupt
	always_comb begin
		rd_raw = 16'h0000;
		if (hit(ADDR, `TX_IRQ_EN_OFS)) begin
			rd_raw = tx_en_ff;
		end else if (hit(ADDR, `RX_IRQ_EN_OFS)) begin
			rd_raw = rx_en_ff;
		end else if (hit(ADDR, `BUS_IRQ_STAT_OFS)) begin
			rd_raw = {8'h00, status_vec};
		end else if (hit(ADDR, `BUS_IRQ_EN_OFS)) begin
			rd_raw = {8'h00, bus_en_ff};
		end else if (hit(ADDR, `FRAME_NUM_OFS)) begin
			rd_raw = {5'h00, frame_ff};
		end else if (hit(ADDR, `EP_SEL_OFS)) begin
			rd_raw = {12'h000, ep_sel_ff};
		end else if (hit(ADDR, `MODE_CTRL_OFS)) begin
			rd_raw = {15'h0000, native_ff};
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			rd_win_ff <= 1'b0;
		end else begin
			rd_win_ff <= RD && win_hit;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			rdata_ff <= `RDATA_RST;
		end else if (RD) begin
			rdata_ff <= rd_raw & read_mask(ADDR);
		end else begin
			rdata_ff <= `RDATA_RST;
		end
	end

	always_comb begin
		RDATA = rd_win_ff ? mem_rdata : rdata_ff;
	end

	always_ff @(posedge CORE_CLK) begin
		if (SRST) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_status & bus_en_ff);
		end
	end

	assign BUS_IRQ = irq_ff;
	assign NATIVE_IRQ_ACCESS = native_ff;
	assign ENDPOINT_SEL = ep_sel_ff;
	assign TX_IRQ_EN = tx_en_ff;
	assign RX_IRQ_EN = rx_en_ff;
endmodule // usb_irq_index

// ===== hdl/usb_irq_regs.svh
/*
 Offsets, field positions, reset values and read masks for the
 common interrupt and index register block.
 Assumes inclusion from the design modules only.
*/
`ifndef USB_IRQ_REGS_SVH
`define USB_IRQ_REGS_SVH

`define TX_IRQ_EN_OFS 4'h0
`define RX_IRQ_EN_OFS 4'h1
`define BUS_IRQ_STAT_OFS 4'h2
`define BUS_IRQ_EN_OFS 4'h3
`define FRAME_NUM_OFS 4'h4
`define EP_SEL_OFS 4'h5
`define MODE_CTRL_OFS 4'h6
`define IDX_WIN_OFS 4'h8

`define SUPPLY_ERR_BIT 7
`define SESS_REQ_BIT 6
`define DISCONNECT_BIT 5
`define CONNECT_BIT 4
`define FRAME_START_BIT 3
`define RESET_BABBLE_BIT 2
`define RESUME_BIT 1
`define SUSPEND_BIT 0

`define TX_IRQ_EN_RST 16'h001F
`define TX_IRQ_EN_MASK 16'h001F
`define RX_IRQ_EN_RST 16'h001E
`define RX_IRQ_EN_MASK 16'h001E
`define BUS_IRQ_EN_RST 8'h06
`define EP_SEL_RST 4'h0
`define FRAME_NUM_MASK 16'h07FF
`define BUS_IRQ_MASK 16'h00FF
`define EP_SEL_MASK 16'h000F
`define MODE_CTRL_MASK 16'h0001
`define STATUS_RST 8'h00
`define FLAG_RST 1'b0
`define FRAME_NUM_RST 11'h000
`define NATIVE_RST 1'b0
`define RDATA_RST 16'h0000

`endif

// ===== hdl/usb_irq_pkg.sv
/*
 Types shared by the interrupt and index register block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package usb_irq_pkg;
	typedef logic [3:0] reg_addr_t;
	typedef logic [15:0] reg_data_t;
	typedef logic [7:0] bus_irq_t;
	typedef enum logic {
		ROLE_PERIPHERAL,
		ROLE_HOST
	} role_t;
endpackage

// ===== hdl/ep_csr_mem.sv
/*
 Small memory holding the per-endpoint control and status words that
 appear through the indexed window.
 Assumes one write or one read per cycle from the register block.
*/
`include "usb_irq_regs.svh"

module ep_csr_mem #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data_ff
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		rd_data_ff <= mem[rd_addr];
	end
endmodule // ep_csr_mem

// ===== sim/usb_irq_index_assertions.sv
/* Checker for the interrupt and index registers.
 Assumes binding to usb_irq_index. */
module usb_irq_index_chk (
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic [3:0] ADDR,
	input wire logic [15:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [15:0] RDATA,
	input wire logic FRAME_START,
	input wire logic [10:0] FRAME_RX_NUM,
	input wire logic [3:0] ENDPOINT_SEL,
	input wire logic [15:0] TX_IRQ_EN,
	input wire logic [15:0] RX_IRQ_EN
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	sequence r(logic [3:0] a);
		RD && ADDR == a;
	endsequence
	sequence w(logic [3:0] a);
		WR && ADDR == a;
	endsequence
	sequence sof_r(logic [3:0] a);
		FRAME_START ##1 r(a);
	endsequence
	AST_TX_WR: assert property (
		w(4'h0) |=> TX_IRQ_EN == ($past(WDATA) & 16'h001F))
		else $error("tx enable");
	AST_RX_WR: assert property (
		w(4'h1) |=> RX_IRQ_EN == ($past(WDATA) & 16'h001E))
		else $error("rx enable");
	AST_SEL_WR: assert property (
		w(4'h5) |=> {12'h000, ENDPOINT_SEL} == ($past(WDATA) & 16'h000F))
		else $error("select write");
	AST_SEL_RD: assert property (
		r(4'h5) |=> RDATA == {12'h000, ENDPOINT_SEL})
		else $error("select read");
	AST_FRAME_HI: assert property (
		r(4'h4) |=> RDATA[15:11] == 5'h00)
		else $error("frame upper");
	AST_FRAME_CAP: assert property (
		sof_r(4'h4) |=> RDATA == {5'h00, $past(FRAME_RX_NUM, 2)})
		else $error("frame capture");
	AST_SOF_SET: assert property (
		sof_r(4'h2) |=> RDATA[3])
		else $error("frame flag");
	AST_BEN_RB: assert property (
		w(4'h3) ##1 !WR ##1 r(4'h3) |=> RDATA == ($past(WDATA, 3) & 16'h00FF))
		else $error("bus enable");
endmodule // usb_irq_index_chk
////////////////////////////////////////////////////////////////////////////
bind usb_irq_index usb_irq_index_chk chk (.CORE_CLK, .SRST, .ADDR, .WDATA,
	.WR, .RD, .RDATA, .FRAME_START, .FRAME_RX_NUM, .ENDPOINT_SEL,
	.TX_IRQ_EN, .RX_IRQ_EN);

// ===== sim/usb_bus_model.sv
/* Far-side bus model: one-cycle event pulses and frame numbers.
 Assumes send is called by the bench. */
module usb_bus_model (
	input wire logic clk,
	output logic [9:0] ev,
	output logic [10:0] fnum
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ev = 10'h000;
		fnum = 11'h000;
	end
	// Frame number flips once the pulse is over
	task automatic send(input int k, input logic [10:0] n);
		@(posedge clk);
		ev[k] <= 1'b1;
		fnum <= n;
		@(posedge clk);
		ev[k] <= 1'b0;
		fnum <= ~n;
	endtask
endmodule // usb_bus_model

// ===== sim/usb_irq_index_tb.sv
/* Bench for the interrupt and index registers.
 Assumes the bus model and the bound checker. */
module usb_irq_index_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, srst, wr, rd, host, a_dev, sess, susp, irq, native;
	logic [3:0] addr, sel;
	logic [15:0] wdata, rdata, d, txe, rxe;
	logic [9:0] ev;
	logic [10:0] fnum;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	usb_bus_model bus (.clk, .ev, .fnum);
	usb_irq_index dut (
		.CORE_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .IS_HOST(host), .IS_A_DEVICE(a_dev),
		.IN_SESSION(sess), .SUSPENDED(susp), .SUPPLY_LOW(ev[7]),
		.SESS_REQ_SEEN(ev[6]), .DISCONNECT_SEEN(ev[5]), .SESSION_END(ev[9]),
		.CONNECT_SEEN(ev[4]), .FRAME_START(ev[3]), .FRAME_RX_NUM(fnum),
		.BUS_RESET_SEEN(ev[2]), .BABBLE_SEEN(ev[8]), .RESUME_SEEN(ev[1]),
		.SUSPEND_SEEN(ev[0]), .BUS_IRQ(irq), .NATIVE_IRQ_ACCESS(native),
		.ENDPOINT_SEL(sel), .TX_IRQ_EN(txe), .RX_IRQ_EN(rxe)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic chk(string s, logic [15:0] e, logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic wrr(logic [3:0] a, logic [15:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rdd(logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic rc(logic [3:0] a, logic [15:0] e);
		rdd(a);
		chk($sformatf("reg %h", a), e, d);
	endtask
	task automatic seeirq(logic e);
		repeat (2) @(negedge clk);
		chk("irq", {15'h0000, e}, {15'h0000, irq});
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [15:0] rv [7] = '{16'h001F, 16'h001E, 16'h0000, 16'h0006,
			16'h0000, 16'h0000, 16'h0000};
		logic [15:0] wv [7] = '{16'h001F, 16'h001E, 16'h0000, 16'h00FF,
			16'h0000, 16'h000F, 16'h0000};
		logic [3:0] a;
		for (int i = 0; i < 7; i++) begin
			a = (i == 6) ? 4'h7 : 4'(i);
			rc(a, rv[i]);
			wrr(a, 16'hFFFF);
			rc(a, wv[i]);
		end
		chk("tx out", 16'h001F, txe);
		chk("rx out", 16'h001E, rxe);
		chk("sel out", 16'h000F, {12'h000, sel});
	endtask
	task automatic t_events();
		int b;
		for (int k = 0; k < 10; k++) begin
			b = k < 8 ? k : (k == 8 ? 2 : 5);
			@(posedge clk);
			host <= (k == 4 || k == 5 || k == 8);
			rdd(4'h2);
			fork
				bus.send(k, 11'h7FF);
				begin
					@(posedge clk);
					rc(4'h2, 16'h0001 << b);
				end
			join
			rc(4'h2, 16'h0000);
			seeirq(1'b0);
		end
		for (int j = 0; j < 3; j++) begin
			@(posedge clk);
			{susp, a_dev, sess} <= ~(3'h4 >> j);
			rdd(4'h2);
			bus.send(j ? 7 : 1, 11'h000);
			rc(4'h2, 16'h0000);
		end
		@(posedge clk);
		{susp, a_dev, sess} <= 3'h7;
	endtask
	task automatic t_mask();
		wrr(4'h3, 16'h0000);
		rdd(4'h2);
		bus.send(3, 11'h000);
		seeirq(1'b0);
		wrr(4'h3, 16'h0008);
		seeirq(1'b1);
		fork
			bus.send(3, 11'h7FF);
			begin
				@(posedge clk);
				rc(4'h4, 16'h07FF);
			end
		join
		rdd(4'h2);
		seeirq(1'b0);
	endtask
	task automatic t_index();
		for (int i = 0; i < 4; i++) begin
			wrr(4'h5, 16'h0003 << (2 * (i % 2)));
			if (i < 2)
				wrr(4'h8, 16'h1234 + 16'(i));
			else
				rc(4'h8, 16'h1232 + 16'(i));
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			error_cnt++;
			final_report();
		end
	end
	initial begin
		{wr, rd, host, addr, wdata} = '0;
		{srst, a_dev, sess, susp} = '1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		wrr(4'h6, 16'h0001);
		@(negedge clk);
		chk("native", 16'h0001, {15'h0000, native});
		t_regs();
		t_events();
		t_mask();
		t_index();
		final_report();
	end
endmodule // usb_irq_index_tb
